/* nrc_sequencer.sv */
// Purpose: rotation start sequencing, strap capture and shutter commands
// Assumes: straps are static while powered; stop input marks rest
// Notes:   serial framing is outside; this block issues command pulses
//
// Contract
// RULE_01: immediate mode starts rotation without added delay
// RULE_02: delayed mode waits 0.3 s before rotating
// RULE_03: lamp enable gates all light source handling; code gates only shutter close/open, shutter_variant_o ignores lamp
// RULE_04: lamp type picks the command variant
// RULE_05: baud select gives 9600 or 19200 bps
// RULE_06: close shutter on start, open after stop
// RULE_07: lamp users choose delay, lamp, 9.6k, type
// RULE_08: inverted indicator high, or low while rotating
// RULE_09: command accepted after 50 ms low
// RULE_10: straps sampled once after reset, then held
module nrc_sequencer #(
	parameter int QUAL_CYC  = nrc_pkg::QUAL_CYC,
	parameter int DELAY_CYC = nrc_pkg::DELAY_CYC,
	parameter int CNT_W     = nrc_pkg::CNT_W
) (
	input  wire logic                      mclk_i,
	input  wire logic                      rst_i,
	input  wire logic                      rotate_cmd_n_i,
	input  wire logic                      motion_stop_i,
	input  wire logic                      rotation_delay_select_i,
	input  wire logic                      outside_lamp_enable_i,
	input  wire logic                      light_source_type_i,
	input  wire logic                      baud_select_i,
	input  wire logic                      rotation_indication_setting_i,
	output logic                           config_valid_o,
	output logic                           rotate_start_o,
	output logic                           rotating_o,
	output logic                           rotating_indicator_n_o,
	output logic                           shutter_close_o,
	output logic                           shutter_open_o,
	output logic                           shutter_variant_o,
	output logic [nrc_pkg::BAUD_W-1:0]     baud_div_o
);
	localparam logic [CNT_W-1:0] DLY_LAST = CNT_W'(DELAY_CYC - 1);

	nrc_pkg::nrc_state_type       state_ff;
	nrc_pkg::nrc_state_type       nxt_state;
	logic [CNT_W-1:0]             dly_ff;
	logic [CNT_W-1:0]             nxt_dly;
	logic                         taken_ff;
	logic                         nxt_taken;
	logic                         c_delay_ff;
	logic                         nxt_c_delay;
	logic                         c_lamp_ff;
	logic                         nxt_c_lamp;
	logic                         c_type_ff;
	logic                         nxt_c_type;
	logic                         c_baud_ff;
	logic                         nxt_c_baud;
	logic                         c_ind_ff;
	logic                         nxt_c_ind;
	logic                         start_ff;
	logic                         nxt_start;
	logic                         rot_ff;
	logic                         nxt_rot;
	logic                         ind_n_ff;
	logic                         nxt_ind_n;
	logic                         close_ff;
	logic                         nxt_close;
	logic                         open_ff;
	logic                         nxt_open;
	logic                         variant_ff;
	logic                         nxt_variant;
	logic [nrc_pkg::BAUD_W-1:0]   baud_ff;
	logic [nrc_pkg::BAUD_W-1:0]   nxt_baud;
	logic                         qual;

	function automatic logic [nrc_pkg::BAUD_W-1:0] baud_div(input logic hi);
		baud_div = hi ? nrc_pkg::BAUD_HI_DIV : nrc_pkg::BAUD_LO_DIV;
	endfunction

	nrc_low_filter #(
		.QUAL_CYC (QUAL_CYC),
		.CNT_W    (CNT_W)
	) nrc_low_filter_inst (
		.mclk_i    (mclk_i),
		.rst_i     (rst_i),
		.level_n_i (rotate_cmd_n_i),
		.qual_o    (qual)
	);

	// strap capture: one clocked sample after reset release, then frozen
	always_comb begin
		nxt_taken   = 1'h1;
		nxt_c_delay = c_delay_ff;
		nxt_c_lamp  = c_lamp_ff;
		nxt_c_type  = c_type_ff;
		nxt_c_baud  = c_baud_ff;
		nxt_c_ind   = c_ind_ff;
		if (!taken_ff) begin // RULE_10
			nxt_c_delay = rotation_delay_select_i;
			nxt_c_lamp  = outside_lamp_enable_i;
			nxt_c_type  = light_source_type_i;
			nxt_c_baud  = baud_select_i;
			nxt_c_ind   = rotation_indication_setting_i;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			taken_ff   <= 1'h0;
			c_delay_ff <= 1'h0;
			c_lamp_ff  <= 1'h0;
			c_type_ff  <= 1'h0;
			c_baud_ff  <= 1'h0;
			c_ind_ff   <= 1'h0;
		end else begin
			taken_ff   <= nxt_taken;
			c_delay_ff <= nxt_c_delay;
			c_lamp_ff  <= nxt_c_lamp;
			c_type_ff  <= nxt_c_type;
			c_baud_ff  <= nxt_c_baud;
			c_ind_ff   <= nxt_c_ind;
		end
	end

	// rotation sequencing and shutter commands
	always_comb begin
		nxt_state = state_ff;
		nxt_dly   = dly_ff;
		nxt_start = 1'h0;
		nxt_close = 1'h0;
		nxt_open  = 1'h0;
		unique case (state_ff)
			nrc_pkg::ST_IDLE: begin
				if (taken_ff && qual) begin
					if (c_delay_ff == nrc_pkg::SEL_DELAYED) begin
						nxt_state = nrc_pkg::ST_DELAY; // RULE_02
						nxt_dly   = '0;
					end else begin
						nxt_state = nrc_pkg::ST_ROTATE; // RULE_01
						nxt_start = 1'h1;
						nxt_close = c_lamp_ff; // RULE_06
					end
				end
			end
			nrc_pkg::ST_DELAY: begin
				if (dly_ff == DLY_LAST) begin
					nxt_state = nrc_pkg::ST_ROTATE; // RULE_02
					nxt_start = 1'h1;
					nxt_close = c_lamp_ff; // RULE_03
				end else begin
					nxt_dly = dly_ff + 1'h1;
				end
			end
			nrc_pkg::ST_ROTATE: begin
				// ignore stop in the start cycle: the drive has not moved yet
				if (motion_stop_i && !start_ff) begin
					nxt_state = nrc_pkg::ST_IDLE;
					nxt_open  = c_lamp_ff; // RULE_06
				end
			end
			default: begin
				nxt_state = nrc_pkg::ST_IDLE;
			end
		endcase
		nxt_rot     = (nxt_state == nrc_pkg::ST_ROTATE);
		nxt_variant = c_type_ff; // RULE_04
		nxt_baud    = baud_div(c_baud_ff); // RULE_05
		if (c_ind_ff == nrc_pkg::SEL_IND_OFF) begin
			nxt_ind_n = 1'h1; // RULE_08
		end else begin
			nxt_ind_n = !nxt_rot; // RULE_08
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff   <= nrc_pkg::ST_IDLE;
			dly_ff     <= '0;
			start_ff   <= 1'h0;
			rot_ff     <= 1'h0;
			close_ff   <= 1'h0;
			open_ff    <= 1'h0;
			ind_n_ff   <= nrc_pkg::RST_IND_N;
			variant_ff <= 1'h0;
			baud_ff    <= nrc_pkg::BAUD_LO_DIV;
		end else begin
			state_ff   <= nxt_state;
			dly_ff     <= nxt_dly;
			start_ff   <= nxt_start;
			rot_ff     <= nxt_rot;
			close_ff   <= nxt_close;
			open_ff    <= nxt_open;
			ind_n_ff   <= nxt_ind_n;
			variant_ff <= nxt_variant;
			baud_ff    <= nxt_baud;
		end
	end

	assign config_valid_o         = taken_ff;
	assign rotate_start_o         = start_ff;
	assign rotating_o             = rot_ff;
	assign rotating_indicator_n_o = ind_n_ff;
	assign shutter_close_o        = close_ff;
	assign shutter_open_o         = open_ff;
	assign shutter_variant_o      = variant_ff;
	assign baud_div_o             = baud_ff;

	// independent count of cycles spent waiting, for the delay check
	logic [CNT_W-1:0]             seen_ff;
	logic [CNT_W-1:0]             nxt_seen;

	always_comb begin
		nxt_seen = '0;
		if (state_ff == nrc_pkg::ST_DELAY) begin
			nxt_seen = seen_ff + 1'h1;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			seen_ff <= '0;
		end else begin
			seen_ff <= nxt_seen;
		end
	end

	a_immediate_start: assert property ( // RULE_01
		@(posedge mclk_i) disable iff (rst_i)
		state_ff == nrc_pkg::ST_IDLE && taken_ff && qual && !c_delay_ff
		|=> start_ff && rot_ff)
		else $error("immediate mode did not start next cycle");
	a_delay_length: assert property ( // RULE_02
		@(posedge mclk_i) disable iff (rst_i)
		$rose(start_ff) && c_delay_ff |-> seen_ff == CNT_W'(DELAY_CYC))
		else $error("delayed start at wrong count");
	a_delay_no_early: assert property ( // RULE_02
		@(posedge mclk_i) disable iff (rst_i)
		$rose(start_ff) && c_delay_ff |-> $past(state_ff) == nrc_pkg::ST_DELAY)
		else $error("delayed mode started without waiting");
	a_lamp_gate: assert property ( // RULE_03
		@(posedge mclk_i) disable iff (rst_i)
		!c_lamp_ff && taken_ff |-> !close_ff && !open_ff)
		else $error("shutter command without lamp");
	a_type_variant: assert property ( // RULE_04
		@(posedge mclk_i) disable iff (rst_i)
		taken_ff && $past(taken_ff) |-> shutter_variant_o == c_type_ff)
		else $error("variant does not follow lamp type");
	a_baud_rate: assert property ( // RULE_05
		@(posedge mclk_i) disable iff (rst_i)
		taken_ff && $past(taken_ff) |->
		baud_div_o == (c_baud_ff ? 12'h516 : 12'ha2c))
		else $error("baud divisor wrong");
	a_close_on_start: assert property ( // RULE_06
		@(posedge mclk_i) disable iff (rst_i)
		$rose(rot_ff) |-> shutter_close_o == c_lamp_ff && start_ff)
		else $error("close command not with start");
	a_open_on_stop: assert property ( // RULE_06
		@(posedge mclk_i) disable iff (rst_i)
		$fell(rot_ff) |-> shutter_open_o == c_lamp_ff ##1 !shutter_open_o)
		else $error("open command not after stop");
	a_indicator: assert property ( // RULE_08
		@(posedge mclk_i) disable iff (rst_i)
		taken_ff |=> rotating_indicator_n_o == (c_ind_ff | !rot_ff))
		else $error("inverted indicator wrong");
	a_straps_hold: assert property ( // RULE_10
		@(posedge mclk_i) disable iff (rst_i)
		taken_ff |=> $stable({c_delay_ff, c_lamp_ff, c_type_ff, c_baud_ff,
		c_ind_ff}))
		else $error("straps changed after capture");

	c_delayed_run: cover property (@(posedge mclk_i) disable iff (rst_i)
		c_delay_ff && c_lamp_ff && $rose(start_ff));
	c_immediate_run: cover property (@(posedge mclk_i) disable iff (rst_i)
		!c_delay_ff && $rose(start_ff));
	c_shutter_open: cover property (@(posedge mclk_i) disable iff (rst_i)
		shutter_open_o);
endmodule

/* nrc_pkg.sv */
// Purpose: shared constants for the nosepiece rotation and shutter sequencer
// Assumes: 25 MHz system clock
// Notes:   long counts are defaults for module parameters
package nrc_pkg;
	localparam int          CLK_HZ      = 25_000_000;
	localparam int          QUAL_MS     = 50;
	localparam int          DELAY_MS    = 300;
	// least times: exact at this rate, so no rounding is needed
	localparam int          QUAL_CYC    = CLK_HZ / 1000 * QUAL_MS;
	localparam int          DELAY_CYC   = CLK_HZ / 1000 * DELAY_MS;
	localparam int          CNT_W       = 23;
	localparam int          BAUD_LO_BPS = 9600;
	localparam int          BAUD_HI_BPS = 19200;
	localparam int          BAUD_W      = 12;
	localparam logic [11:0] BAUD_LO_DIV = 12'(CLK_HZ / BAUD_LO_BPS);
	localparam logic [11:0] BAUD_HI_DIV = 12'(CLK_HZ / BAUD_HI_BPS);
	localparam logic        RST_IND_N   = 1'h1;
	localparam logic        SEL_DELAYED = 1'h1;
	localparam logic        SEL_IND_OFF = 1'h1;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_DELAY  = 2'h1,
		ST_ROTATE = 2'h3
	} nrc_state_type;
endpackage

/* nrc_low_filter.sv */
// Purpose: accept an active-low command only after it stays low long enough
// Assumes: input synchronous to mclk_i
// Notes:   qual_o rises on the QUAL_CYC-th consecutive low sample
module nrc_low_filter #(
	parameter int QUAL_CYC = nrc_pkg::QUAL_CYC,
	parameter int CNT_W    = nrc_pkg::CNT_W
) (
	input  wire logic mclk_i,
	input  wire logic rst_i,
	input  wire logic level_n_i,
	output logic      qual_o
);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(QUAL_CYC - 1);

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic             qual_ff;
	logic             nxt_qual;

	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_qual = 1'h0;
		if (level_n_i) begin
			nxt_cnt = '0;
		end else if (cnt_ff != LAST) begin
			nxt_cnt = cnt_ff + 1'h1;
		end
		nxt_qual = !level_n_i && (cnt_ff == LAST); // RULE_09
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_ff  <= '0;
			qual_ff <= 1'h0;
		end else begin
			cnt_ff  <= nxt_cnt;
			qual_ff <= nxt_qual;
		end
	end

	assign qual_o = qual_ff;

	a_filter_min_low: assert property ( // RULE_09
		@(posedge mclk_i) disable iff (rst_i)
		$rose(qual_ff) |-> $past(cnt_ff) == LAST && $past(!level_n_i))
		else $error("command accepted before minimum low time");
endmodule

/* nrc_motion_model.sv */
// Purpose: nosepiece mechanics seen from the sequencer's far side
// Assumes: rotation is commanded by the sequencer's rotating level
// Notes:   travel length is set per test so stops come fast or slow
module nrc_motion_model (
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	input  wire logic       rotating_i,
	input  wire logic [7:0] move_len_i,
	output logic            motion_stop_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;

	always_comb begin
		nxt_cnt = rotating_i ? cnt_ff + 8'h01 : 8'h00;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_ff <= 8'h00;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// leaves rest at once, so stop is low in the start cycle unless move_len_i is 0
	assign motion_stop_o = !(rotating_i && (cnt_ff < move_len_i));
endmodule

/* nrc_sequencer_tb_top.sv */
// Purpose: self-checking bench for the rotation and shutter sequencer
// Assumes: shortened qualify and delay counts
// Notes:   each strap set is applied through a fresh reset
module nrc_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int Q = 4;
	localparam int D = 6;
	logic                          mclk_i = 1'b0;
	logic                          rst_i  = 1'b1;
	logic                          cmd_n  = 1'b1;
	logic                          dly    = 1'b0;
	logic                          lamp   = 1'b0;
	logic                          typ    = 1'b0;
	logic                          baud   = 1'b0;
	logic                          ind    = 1'b0;
	logic [7:0]                    mlen   = 8'h02;
	logic                          stop;
	logic                          cfg_ok;
	logic                          start;
	logic                          rot;
	logic                          ind_n;
	logic                          close_c;
	logic                          open_c;
	logic                          variant;
	logic [nrc_pkg::BAUD_W-1:0]    div;
	int                            err_total    = 0;
	int                            total_checks = 0;
	int                            cyc          = 0;
	int                            lat;
	int                            lat_imm;
	// straps {delay, lamp, type, baud, indicator off}
	logic [4:0] cfg [4] = '{5'h00, 5'h18, 5'h1d, 5'h07};
	logic [7:0] len [4] = '{8'h02, 8'h14, 8'h05, 8'h03};

	always #20 mclk_i = ~mclk_i;

	nrc_sequencer #(.QUAL_CYC(Q), .DELAY_CYC(D)) nrc_sequencer_inst (
		.mclk_i(mclk_i), .rst_i(rst_i), .rotate_cmd_n_i(cmd_n),
		.motion_stop_i(stop), .rotation_delay_select_i(dly),
		.outside_lamp_enable_i(lamp), .light_source_type_i(typ),
		.baud_select_i(baud), .rotation_indication_setting_i(ind),
		.config_valid_o(cfg_ok), .rotate_start_o(start), .rotating_o(rot),
		.rotating_indicator_n_o(ind_n), .shutter_close_o(close_c),
		.shutter_open_o(open_c), .shutter_variant_o(variant),
		.baud_div_o(div));

	nrc_motion_model nrc_motion_model_inst (
		.mclk_i(mclk_i), .rst_i(rst_i), .rotating_i(rot),
		.move_len_i(mlen), .motion_stop_o(stop));

	task automatic tally_and_finish();
		if (err_total == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t bit got %b want %b", $time, got, exp);
		end
	endtask

	task automatic chk_div(input logic [11:0] got, input logic [11:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t divisor got %h want %h", $time, got, exp);
		end
	endtask

	task automatic do_reset(input logic [4:0] c, input logic [7:0] l);
		@(posedge mclk_i);
		{dly, lamp, typ, baud, ind} <= c;
		mlen <= l;
		rst_i <= 1'b1;
		repeat (16) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		#1;
		chk_bit(cfg_ok, 1'b1);
		chk_div(div, c[1] ? nrc_pkg::BAUD_HI_DIV : nrc_pkg::BAUD_LO_DIV);
		chk_bit(variant, c[2]);
		chk_bit(ind_n, 1'b1);
	endtask

	task automatic rotate(input logic lamp_e, input logic ind_e, output int n);
		int k;
		@(posedge mclk_i);
		cmd_n <= 1'b0;
		n = 0;
		do begin
			@(posedge mclk_i);
			#1;
			n++;
		end while (start !== 1'b1 && n < 60);
		chk_bit(start, 1'b1);
		chk_bit(rot, 1'b1);
		chk_bit(close_c, lamp_e);
		chk_bit(ind_n, ind_e);
		@(posedge mclk_i);
		cmd_n <= 1'b1;
		#1;
		chk_bit(start, 1'b0);
		chk_bit(close_c, 1'b0);
		k = 0;
		while (rot === 1'b1 && k < 300) begin
			@(posedge mclk_i);
			#1;
			k++;
		end
		chk_bit(rot, 1'b0);
		chk_bit(open_c, lamp_e);
		chk_bit(ind_n, 1'b1);
		@(posedge mclk_i);
		#1;
		chk_bit(open_c, 1'b0);
	endtask

	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end

	initial begin
		lat_imm = 0;
		for (int i = 0; i < 4; i++) begin
			do_reset(cfg[i], len[i]);
			repeat (2) rotate(cfg[i][3], cfg[i][0], lat);
			if (cfg[i][4]) begin
				chk_bit(lat - lat_imm >= D && lat - lat_imm <= D + 1, 1'b1);
			end else begin
				lat_imm = lat;
				chk_bit(lat >= Q + 1 && lat <= Q + 3, 1'b1);
			end
		end
		// one low sample short of qualifying
		@(posedge mclk_i);
		cmd_n <= 1'b0;
		repeat (3) @(posedge mclk_i);
		cmd_n <= 1'b1;
		// watch every cycle: a false start would be over before the end
		repeat (10) begin
			@(posedge mclk_i);
			#1;
			chk_bit(rot, 1'b0);
		end
		// straps moved while powered must be ignored
		@(posedge mclk_i);
		baud <= 1'b0;
		typ  <= 1'b0;
		repeat (4) @(posedge mclk_i);
		#1;
		chk_div(div, nrc_pkg::BAUD_HI_DIV);
		chk_bit(variant, 1'b1);
		tally_and_finish();
	end
endmodule
